// [core/kwd_defs.svh]
/*
 * Constants of the keyed watchdog: register addresses, reset values, key
 * bytes, field positions and overflow shift bases.
 * Assumes inclusion by bare name from the watchdog design files.
 */
`ifndef KWD_DEFS_SVH
`define KWD_DEFS_SVH

`define KWD_MODE_ADDR     16'hFF98
`define KWD_KEY_ADDR      16'hFF99
`define KWD_MODE_RST      8'h67
`define KWD_KEY_RST       8'h9A
`define KWD_KEY_RESTART   8'hAC
`define KWD_MODE_TOP      3'h3
`define KWD_CS_HI_BIT     4
`define KWD_CS_LO_BIT     3
`define KWD_IVL_MSB       2
`define KWD_IVL_LSB       0
`define KWD_IVL_MAX       3'h7
`define KWD_RING_SHIFT    5'h0B
`define KWD_XTAL_SHIFT    5'h0D
`define KWD_CNT_W         21

`endif

// [core/kwd_pkg.sv]
/*
 * Types shared by the keyed watchdog modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package kwd_pkg;

    // pause and resume sequencing of the count source
    typedef enum logic [1:0] {
        KWD_RUN,
        KWD_PAUSED,
        KWD_SETTLE
    } kwd_state_t;

endpackage

// [core/kwd_cnt_if.sv]
/*
 * Carrier between the watchdog control logic and its up-counter.
 * Assumes both ends share sys_clk_i and one counter width.
 */
`timescale 1ns/10ps
interface kwd_cnt_if #(parameter int CNT_W = 21);
    logic             clr;
    logic             tick;
    logic [CNT_W-1:0] term_last;
    logic [CNT_W-1:0] count;
    logic             ovf;

    modport ctl (output clr, output tick, output term_last, input count, input ovf);
    modport cnt (input clr, input tick, input term_last, output count, output ovf);
endinterface

// [core/kwd_counter.sv]
/*
 * Free-running watchdog up-counter with terminal-count compare.
 * Assumes tick is a one-cycle enable from the selected count source.
 */
`timescale 1ns/10ps
module kwd_counter
    import kwd_pkg::*;
#(
    parameter int CNT_W = 21
)(
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    kwd_cnt_if.cnt    cnt_if
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic             at_term;

    // overflow only on a real tick at the last value
    assign at_term    = (count_r == cnt_if.term_last);
    assign cnt_if.ovf = cnt_if.tick && at_term && !cnt_if.clr;
    assign count_nxt  = cnt_if.clr ? '0 :
                        (cnt_if.tick ? (at_term ? '0 : count_r + 1'b1) : count_r);
    assign cnt_if.count = count_r;

    // clear wins over a tick in the same cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end
endmodule

// [core/kwd_top.sv]
/*
 * Keyed watchdog: mode and key registers on the CPU 8-bit port, count
 * source selection, HALT/STOP pause and resume, internal reset request.
 * Assumes ring and crystal ticks are one-cycle enables synchronous to
 * sys_clk_i, and the stoppable option input is static.
 */
// Overview of operation
// - key byte ACH clears the counter, counting restarts from zero
// - key register resets to 9AH and always reads 9AH
// - running watchdog, wrong key byte requests internal reset
// - running watchdog, single-bit access to key requests internal reset
// - violation while source clock stopped is held, issued on resume
// - counter reaching selected interval requests internal reset
// - running watchdog, second mode write requests internal reset
// - after software stop, no violation resets; watchdog stays stopped
// - after reset, count at once on ring clock, interval code 111
// - non-stoppable build keeps ring clock, ignores mode bits 3 and 4
// - non-stoppable build never stops counting, even in STOP
// - the first (accepted) mode write clears the counter
// - stoppable build selects ring, crystal or stop by bits 3 and 4
// - stoppable build pauses in HALT and STOP, keeps count on wake
// - crystal CPU and crystal source at STOP wait for settle time
// - ring CPU, crystal source: wait for settle or CPU on crystal
// - ring source at STOP resumes right after release
// - mode register resets to 67H, one write accepted, reads unlimited
// - clock field 00 ring, 01 crystal, 1x stopped
// - interval n gives 2^(11+n) ring or 2^(13+n) crystal cycles
`timescale 1ns/10ps
`include "kwd_defs.svh"
module kwd_top
    import kwd_pkg::*;
#(
    parameter int CNT_W = `KWD_CNT_W
)(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        stoppable_i,
    input  wire logic        ring_tick_i,
    input  wire logic        xtal_tick_i,
    input  wire logic        halt_i,
    input  wire logic        stop_i,
    input  wire logic        cpu_on_xtal_i,
    input  wire logic        osc_settled_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic        bit_op_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    output logic             wdt_reset_o
);
    kwd_cnt_if #(.CNT_W(CNT_W)) cnt_if ();

    logic [7:0]  mode_r;
    logic        mode_done_r;
    logic        pend_r;
    logic        reset_req_r;
    logic        src_xtal_stop_r;
    logic        cpu_ring_stop_r;
    logic [7:0]  rdata_r;
    kwd_state_t  state_r;
    kwd_state_t  state_nxt;

    // address decode
    wire sel_mode     = (addr_i == `KWD_MODE_ADDR);
    wire sel_key      = (addr_i == `KWD_KEY_ADDR);
    wire mode_wr      = wr_i && sel_mode && !bit_op_i;
    wire key_wr8      = wr_i && sel_key && !bit_op_i;
    wire key_bitop    = sel_key && bit_op_i && (wr_i || rd_i);
    wire key_good     = key_wr8 && (wdata_i == `KWD_KEY_RESTART);

    // clock field; the non-stoppable build has no stop and no crystal
    wire cs_hi        = stoppable_i && mode_r[`KWD_CS_HI_BIT];
    wire cs_lo        = stoppable_i && mode_r[`KWD_CS_LO_BIT];
    wire wdt_stopped  = cs_hi;
    wire src_xtal     = !cs_hi && cs_lo;
    wire [2:0] ivl    = mode_r[`KWD_IVL_MSB:`KWD_IVL_LSB];

    // source clock considered stopped while paused or settling
    wire src_paused   = stoppable_i && (state_r != KWD_RUN);
    wire src_tick     = src_xtal ? xtal_tick_i : ring_tick_i;

    // violations are dropped entirely once software stopped the watchdog
    wire bad_key      = key_wr8 && !key_good;
    wire second_mode  = mode_wr && mode_done_r;
    wire violation    = !wdt_stopped && (bad_key || key_bitop || second_mode);
    wire fire_now     = (violation || pend_r) && !src_paused;
    wire first_mode   = mode_wr && !mode_done_r;

    // last counter value of the selected interval
    function automatic logic [CNT_W-1:0] term_of(input logic xtal, input logic [2:0] n);
        logic [4:0] sh;
        sh = (xtal ? `KWD_XTAL_SHIFT : `KWD_RING_SHIFT) + {2'h0, n};
        term_of = CNT_W'((CNT_W+1)'(1) << sh) - CNT_W'(1);
    endfunction

    assign cnt_if.term_last = term_of(src_xtal, ivl);
    assign cnt_if.tick      = src_tick && !wdt_stopped && !src_paused;
    assign cnt_if.clr       = key_good || first_mode;

    kwd_counter #(.CNT_W(CNT_W)) u_counter (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .cnt_if    (cnt_if)
    );

    // mode register: reset value selects ring clock, longest interval
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_r      <= `KWD_MODE_RST;
            mode_done_r <= 1'b0;
        end
        else if (first_mode)
        begin
            // top bits held at 011 whatever software puts there
            mode_r      <= {`KWD_MODE_TOP, wdata_i[`KWD_CS_HI_BIT:`KWD_IVL_LSB]};
            mode_done_r <= 1'b1;
        end
    end

    // pending reset waits for the source clock to come back
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pend_r <= 1'b0;
        else if (violation && src_paused)
            pend_r <= 1'b1;
        else if (!src_paused)
            pend_r <= 1'b0;
    end

    // sticky request: the chip reset that follows clears it
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            reset_req_r <= 1'b0;
        else if (fire_now || cnt_if.ovf)
            reset_req_r <= 1'b1;
    end

    // pause sequencer, only the stoppable build ever leaves RUN
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            KWD_RUN:
                if (stoppable_i && (halt_i || stop_i))
                    state_nxt = KWD_PAUSED;
            KWD_PAUSED:
                if (!halt_i && !stop_i)
                    state_nxt = src_xtal_stop_r ? KWD_SETTLE : KWD_RUN;
            KWD_SETTLE:
                if (osc_settled_i || (cpu_ring_stop_r && cpu_on_xtal_i))
                    state_nxt = KWD_RUN;
            default:
                state_nxt = KWD_RUN;
        endcase
    end

    // remember clock situation at STOP entry
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r         <= KWD_RUN;
            src_xtal_stop_r <= 1'b0;
            cpu_ring_stop_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == KWD_RUN && state_nxt == KWD_PAUSED)
            begin
                src_xtal_stop_r <= stop_i && src_xtal;
                cpu_ring_stop_r <= !cpu_on_xtal_i;
            end
        end
    end

    // reads: the key register always returns its fixed pattern
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_r <= 8'h00;
        else if (rd_i && sel_key)
            rdata_r <= `KWD_KEY_RST;
        else if (rd_i && sel_mode)
            rdata_r <= mode_r;
    end

    assign rdata_o     = rdata_r;
    assign wdt_reset_o = reset_req_r;

    // checks
    sequence seq_bad_access;
        violation && !src_paused;
    endsequence

    sequence seq_req_next;
        ##1 wdt_reset_o;
    endsequence

    AST_KEY_CLEAR: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        key_good |=> (cnt_if.count == '0))
        else $error("restart key did not clear the counter");

    AST_KEY_READ: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (rd_i && sel_key) |=> (rdata_o == `KWD_KEY_RST))
        else $error("key register read not fixed pattern");

    AST_BAD_KEY: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (bad_key && !wdt_stopped && !src_paused) |=> wdt_reset_o)
        else $error("wrong key did not request reset");

    AST_BIT_KEY: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (key_bitop && !wdt_stopped) ##0 seq_bad_access |-> seq_req_next)
        else $error("bit access to key did not request reset");

    AST_PEND_FIRE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (pend_r && !src_paused) |=> wdt_reset_o)
        else $error("held reset not issued on resume");

    AST_PEND_HOLD: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (violation && src_paused && !wdt_reset_o) |=> (pend_r && !wdt_reset_o))
        else $error("violation during pause not held");

    AST_OVF: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cnt_if.ovf |-> seq_req_next)
        else $error("overflow did not request reset");

    AST_SECOND_MODE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (second_mode && !wdt_stopped) ##0 seq_bad_access |-> seq_req_next)
        else $error("second mode write did not request reset");

    AST_STOPPED_QUIET: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wdt_stopped && !wdt_reset_o && !pend_r) |=> !wdt_reset_o)
        else $error("stopped watchdog requested reset");

    AST_NONSTOP_RING: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !stoppable_i |-> (!src_xtal && !wdt_stopped))
        else $error("non-stoppable build left the ring clock");

    AST_NONSTOP_COUNT: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (!stoppable_i && ring_tick_i && !cnt_if.clr && !cnt_if.ovf)
        |=> (cnt_if.count == $past(cnt_if.count) + 1'b1))
        else $error("non-stoppable counter missed a tick");

    AST_MODE_CLEAR: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        first_mode |=> (cnt_if.count == '0) && mode_done_r)
        else $error("mode write did not clear the counter");

    AST_PAUSE_HOLD: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (src_paused && !cnt_if.clr) |=> $stable(cnt_if.count))
        else $error("counter moved while paused");

    AST_SETTLE_WAIT: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_r == KWD_SETTLE && !osc_settled_i && !(cpu_ring_stop_r && cpu_on_xtal_i))
        |=> (state_r == KWD_SETTLE))
        else $error("left settle wait early");

    AST_RING_RESUME: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_r == KWD_PAUSED && !halt_i && !stop_i && !src_xtal_stop_r)
        |=> (state_r == KWD_RUN))
        else $error("ring source did not resume at once");

    AST_ONE_WRITE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (mode_done_r && mode_wr) |=> $stable(mode_r))
        else $error("mode register took a second write");

    // wake-up: the sequencer is back in RUN one edge later
    sequence seq_run_next;
        ##1 (state_r == KWD_RUN);
    endsequence

    AST_START_RING: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !mode_done_r |-> (!src_xtal && !wdt_stopped && (ivl == `KWD_IVL_MAX)))
        else $error("reset state not ring clock at longest interval");

    AST_KEY_NO_RESET: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (key_good && !pend_r && !wdt_reset_o) |=> !wdt_reset_o)
        else $error("restart key requested reset");

    AST_STOPPED_FROZEN: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wdt_stopped && !cnt_if.clr) |=> $stable(cnt_if.count))
        else $error("stopped watchdog kept counting");

    AST_BITOP_MODE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_i && sel_mode && bit_op_i) |=> $stable(mode_r))
        else $error("bit write to mode register was stored");

    AST_NONSTOP_NO_PAUSE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (!stoppable_i && (halt_i || stop_i)) |=> (state_r == KWD_RUN))
        else $error("non-stoppable build paused");

    AST_PAUSE_ENTRY: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (stoppable_i && (state_r == KWD_RUN) && (halt_i || stop_i)) |=> (state_r == KWD_PAUSED))
        else $error("standby did not pause the watchdog");

    AST_RESUME_KEEP: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ((state_r != KWD_RUN) && (state_nxt == KWD_RUN) && !cnt_if.clr)
        |=> $stable(cnt_if.count))
        else $error("counter changed on wake-up");

    AST_SETTLE_ENTRY: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ((state_r == KWD_PAUSED) && !halt_i && !stop_i && src_xtal_stop_r)
        |=> (state_r == KWD_SETTLE))
        else $error("crystal source resumed without settle wait");

    AST_SETTLE_DONE: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ((state_r == KWD_SETTLE) && osc_settled_i) |-> seq_run_next)
        else $error("settle done but counting not resumed");

    AST_CPU_SWITCH: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ((state_r == KWD_SETTLE) && cpu_ring_stop_r && cpu_on_xtal_i) |-> seq_run_next)
        else $error("cpu switch to crystal did not resume counting");
endmodule

// [dv/kwd_cpu_model.sv]
/*
 * CPU-side model: issues 8-bit and 1-bit accesses to the watchdog registers.
 * Assumes the watchdog samples the strobes on the rising edge of sys_clk_i.
 */
`timescale 1ns/10ps
module kwd_cpu_model (
    input  wire logic        sys_clk_i,
    output logic      [15:0] addr_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic             bit_op_o,
    output logic      [7:0]  wdata_o,
    input  wire logic [7:0]  rdata_i
);
    // idle bus at time zero, no strobe raised
    initial
    begin
        addr_o   = 16'h0000;
        wr_o     = 1'b0;
        rd_o     = 1'b0;
        bit_op_o = 1'b0;
        wdata_o  = 8'h00;
    end

    // one access: raise on a falling edge, drop on the next one
    task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w,
                          input logic b, output logic [7:0] q);
        @(negedge sys_clk_i);
        addr_o   = a;
        wdata_o  = d;
        wr_o     = w;
        rd_o     = !w;
        bit_op_o = b;
        @(negedge sys_clk_i);
        q        = rdata_i;
        wr_o     = 1'b0;
        rd_o     = 1'b0;
        bit_op_o = 1'b0;
        // released lines carry the inverse so stale values never look valid
        addr_o   = ~addr_o;
        wdata_o  = ~wdata_o;
    endtask

    task automatic wr8(input logic [15:0] a, input logic [7:0] d, input logic b);
        logic [7:0] q;
        access(a, d, 1'b1, b, q);
    endtask

    task automatic rd8(input logic [15:0] a, output logic [7:0] q);
        access(a, 8'h00, 1'b0, 1'b0, q);
    endtask

    // software always places 0,1,1 in the top three mode bits
    task automatic wr_mode(input logic [4:0] lo);
        wr8(16'hFF98, {3'h3, lo}, 1'b0);
    endtask
endmodule

// [dv/tb.sv]
/*
 * Self-checking bench for the keyed watchdog: registers, violations,
 * overflow per source and pause/resume with pending reset.
 * Assumes kwd_top and kwd_cpu_model; ticks are driven here, every cycle in the overflow test only.
 */
`timescale 1ns/10ps
module tb;
    logic        sys_clk_i, rst_n_i, stoppable_i, ring_tick_i, xtal_tick_i;
    logic        halt_i, stop_i, cpu_on_xtal_i, osc_settled_i;
    logic        wr_i, rd_i, bit_op_i, wdt_reset_o;
    logic [15:0] addr_i;
    logic [7:0]  wdata_i, rdata_o, rd_v;
    logic [4:0]  mode_lo;
    int          miscompares, total_checks, i, lim;

    kwd_top kwd_top_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .stoppable_i(stoppable_i), .ring_tick_i(ring_tick_i),
        .xtal_tick_i(xtal_tick_i), .halt_i(halt_i), .stop_i(stop_i),
        .cpu_on_xtal_i(cpu_on_xtal_i), .osc_settled_i(osc_settled_i),
        .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .bit_op_i(bit_op_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .wdt_reset_o(wdt_reset_o));
    kwd_cpu_model kwd_cpu_model_inst (.sys_clk_i(sys_clk_i), .addr_o(addr_i),
        .wr_o(wr_i), .rd_o(rd_i), .bit_op_o(bit_op_i), .wdata_o(wdata_i),
        .rdata_i(rdata_o));

    // 250 MHz clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rst(input logic e, input int n);
        repeat (n) @(negedge sys_clk_i);
        chk("wdt_reset_o", {7'h00, e}, {7'h00, wdt_reset_o});
    endtask

    // fresh reset each test since the reset request is sticky
    task automatic start(input logic opt);
        @(negedge sys_clk_i);
        rst_n_i       = 1'b0;
        stoppable_i   = opt;
        ring_tick_i   = 1'b0;
        xtal_tick_i   = 1'b0;
        halt_i        = 1'b0;
        stop_i        = 1'b0;
        cpu_on_xtal_i = 1'b0;
        osc_settled_i = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        rst_n_i       = 1'b1;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // watchdog: the tests need about 15.5k cycles, allow 50k
    initial
    begin
        #200000;
        miscompares++;
        close_out();
    end

    initial
    begin
        miscompares  = 0;
        total_checks = 0;
        rst_n_i      = 1'b0;
        start(1'b1);
        kwd_cpu_model_inst.rd8(16'hFF99, rd_v);
        chk("key", 8'h9A, rd_v);
        kwd_cpu_model_inst.rd8(16'hFF98, rd_v);
        chk("mode", 8'h67, rd_v);
        kwd_cpu_model_inst.wr8(16'hFF99, 8'hAC, 1'b0);
        // a 1-bit write to the mode register is ignored and uses up nothing
        kwd_cpu_model_inst.wr8(16'hFF98, 8'h6F, 1'b1);
        kwd_cpu_model_inst.rd8(16'hFF98, rd_v);
        chk("mode", 8'h67, rd_v);
        kwd_cpu_model_inst.rd8(16'hFF99, rd_v);
        chk("key", 8'h9A, rd_v);
        kwd_cpu_model_inst.rd8(16'h0066, rd_v);
        chk("rdata kept", 8'h9A, rd_v);
        chk_rst(1'b0, 4);
        $display("test registers done");

        // wrong key, 1-bit key write, 1-bit key read, second mode write
        for (i = 0; i < 4; i++)
        begin
            start(1'b1);
            if (i == 0)
                kwd_cpu_model_inst.wr8(16'hFF99, 8'h00, 1'b0);
            else if (i == 1)
                kwd_cpu_model_inst.wr8(16'hFF99, 8'hAC, 1'b1);
            else if (i == 2)
                kwd_cpu_model_inst.access(16'hFF99, 8'h00, 1'b0, 1'b1, rd_v);
            else
            begin
                kwd_cpu_model_inst.wr_mode(5'h07);
                kwd_cpu_model_inst.wr_mode(5'h07);
            end
            chk_rst(1'b1, 3);
        end
        start(1'b1);
        kwd_cpu_model_inst.wr_mode(5'h10);
        kwd_cpu_model_inst.rd8(16'hFF98, rd_v);
        chk("mode", 8'h70, rd_v);
        kwd_cpu_model_inst.wr8(16'hFF99, 8'h00, 1'b0);
        kwd_cpu_model_inst.wr8(16'hFF99, 8'hAC, 1'b1);
        kwd_cpu_model_inst.wr_mode(5'h00);
        kwd_cpu_model_inst.rd8(16'hFF98, rd_v);
        chk("mode", 8'h70, rd_v);
        chk_rst(1'b0, 4);
        $display("test violations done");

        // overflow: non-stoppable in STOP, stoppable ring, stoppable crystal
        for (i = 0; i < 3; i++)
        begin
            start(i != 0);
            lim = (i == 2) ? 8192 : 2048;
            mode_lo = (i == 2) ? 5'h08 : ((i == 0) ? 5'h18 : 5'h00);
            kwd_cpu_model_inst.wr_mode(mode_lo);
            stop_i      = (i == 0);
            // only the selected source ticks, so a wrong source never overflows
            ring_tick_i = (i != 2);
            xtal_tick_i = (i == 2);
            repeat (1000) @(negedge sys_clk_i);
            // restart, during STOP in the non-stoppable pass, as the auxiliary timer interrupt would
            kwd_cpu_model_inst.wr8(16'hFF99, 8'hAC, 1'b0);
            // one tick per cycle: the request shows exactly lim cycles after restart
            chk_rst(1'b0, lim - 1);
            chk_rst(1'b1, 1);
            ring_tick_i = 1'b0;
            xtal_tick_i = 1'b0;
            stop_i      = 1'b0;
        end
        $display("test overflow done");

        // violation while paused: HALT ring, STOP crystal with settle or CPU switch
        for (i = 0; i < 3; i++)
        begin
            start(1'b1);
            kwd_cpu_model_inst.wr_mode((i == 0) ? 5'h00 : 5'h08);
            cpu_on_xtal_i = (i == 1);
            halt_i        = (i == 0);
            stop_i        = (i != 0);
            repeat (2) @(negedge sys_clk_i);
            kwd_cpu_model_inst.wr8(16'hFF99, 8'h00, 1'b0);
            chk_rst(1'b0, 4);
            halt_i = 1'b0;
            stop_i = 1'b0;
            if (i != 0)
            begin
                chk_rst(1'b0, 6);
                osc_settled_i = (i == 1);
                cpu_on_xtal_i = 1'b1;
            end
            chk_rst(1'b1, 3);
        end
        $display("test pause done");
        close_out();
    end
endmodule
